// File: rtl/tap_pkg.sv
// Purpose: Shared constants, types and step lookup for the tap timing block.
// Assumes: 125 MHz system clock; register addresses are byte offsets on an 8-bit port.
// Notes:   Step lengths are kept as powers of two of the 0.625 ms base step.
package tap_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_Z_THRESH    = 8'h25;
  localparam logic [7:0] ADDR_WIDTH_LIMIT = 8'h26;
  localparam logic [7:0] ADDR_LATENCY     = 8'h27;
  localparam logic [7:0] ADDR_WINDOW      = 8'h28;
  localparam logic [7:0] ADDR_CTRL        = 8'h30;
  localparam logic [7:0] ADDR_STATUS      = 8'h31;

  // Reset values and field masks.
  localparam logic [7:0] RESET_REG   = 8'h00;
  localparam logic [7:0] THRESH_MASK = 8'h7f;
  localparam int         MAG_LSB     = 6;

  // Timing: the base step is the shortest tabulated step.
  localparam real         STEP_BASE_MS     = 0.625;
  localparam real         CLK_PERIOD_NS    = 8.0;
  localparam int unsigned STEP_BASE_CYCLES = int'(STEP_BASE_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int          STEP_W           = 32;
  localparam int          EXP_W            = 4;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_LOW_NOISE,
    MODE_HIGH_RES,
    MODE_LOW_POWER
  } power_mode_type;

  typedef struct packed {
    logic           double_en;
    logic           hybrid;
    logic           hpf_en;
    power_mode_type mode;
    logic [2:0]     sample_rate;
  } ctrl_type;

  typedef struct packed {
    logic double_tap;
    logic single_tap;
  } tap_event_type;

  // Width-limit step as a power of two of the base step.
  // Rate codes 0..7 stand for 800, 400, 200, 100, 50, 12.5, 6.25 and 1.56 Hz.
  function automatic logic [EXP_W-1:0] width_step_exp(input logic [2:0] rate,
                                                      input power_mode_type mode,
                                                      input logic hpf_en);
    logic [EXP_W-1:0] raw;
    logic [EXP_W-1:0] cap;
    raw = {1'b0, rate} + {3'h0, (rate >= 3'h5)};
    if (mode == MODE_HIGH_RES)
    begin
      raw = hpf_en ? ((rate == 3'h0) ? 4'h1 : 4'h2) : 4'h0;
      cap = 4'h2;
    end
    else if (hpf_en)
    begin
      raw = raw + 4'h1;
      cap = (mode == MODE_NORMAL) ? 4'h5 : (mode == MODE_LOW_NOISE) ? 4'h7 : 4'h8;
    end
    else
    begin
      if (mode != MODE_LOW_POWER)
      begin
        raw = (raw == 4'h0) ? 4'h0 : raw - 4'h1;
      end
      cap = (mode == MODE_NORMAL) ? 4'h3 : (mode == MODE_LOW_NOISE) ? 4'h5 : 4'h6;
    end
    return (raw > cap) ? cap : raw;
  endfunction

endpackage

// File: rtl/tap_step_timer.sv
// Purpose: Counts a programmed number of steps, each a given number of clock cycles.
// Assumes: step_cycles is at least one and stays steady while the timer runs.
// Notes:   expired stays high from the last step until the next start.
`timescale 1ns/100ps
module tap_step_timer #(
  parameter int STEP_W = 32
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Control.
  input  wire logic              start,
  input  wire logic [7:0]        limit,
  input  wire logic [STEP_W-1:0] step_cycles,
  // Status.
  output logic                   expired
);

  typedef struct packed {
    logic              active;
    logic [STEP_W-1:0] pre;
    logic [7:0]        steps;
  } timer_state_type;

  timer_state_type s;
  timer_state_type next_s;

  assign expired = s.active && (s.steps == limit);

  always_comb
  begin
    next_s = s;
    if (start)
    begin
      next_s.active = 1'b1;
      next_s.pre    = '0;
      next_s.steps  = 8'h00;
    end
    else if (s.active && !expired)
    begin
      if (s.pre == step_cycles - 1'b1)
      begin
        next_s.pre   = '0;
        next_s.steps = s.steps + 8'h01;
      end
      else
      begin
        next_s.pre = s.pre + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  AST_TIMER_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    (start && limit == 8'h00) ##1 (limit == 8'h00) |-> expired)
    else $error("Zero limit did not expire at once.");

  AST_TIMER_STEP: assert property (@(posedge clk) disable iff (!arst_n)
    (s.active && !expired && !start && s.pre == step_cycles - 1'b1) |=> (s.steps == $past(s.steps) + 8'h01))
    else $error("Step counter did not advance at the end of a step.");

endmodule

// File: rtl/tap_pulse_timing_config.sv
// Purpose: Z-axis tap threshold, pulse width limit, latency and window timing.
// Assumes: Z samples arrive on the system clock at a fixed 8 g scale, 14-bit signed.
// Notes:   Registers sit at their byte offsets on a plain strobe port.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module tap_pulse_timing_config #(
  parameter int unsigned BASE_STEP_CYCLES = tap_pkg::STEP_BASE_CYCLES
) (
  // Clock and reset.
  input  wire logic                   SYS_CLK,
  input  wire logic                   ARST_N,
  // Register port.
  input  wire logic [7:0]             ADDR,
  input  wire logic [7:0]             WR_DATA,
  input  wire logic                   WR_EN,
  input  wire logic                   RD_EN,
  output logic [7:0]                  RD_DATA,
  // Z-axis samples.
  input  wire logic [13:0]            Z_ACCEL,
  input  wire logic                   Z_VALID,
  // Tap results.
  output tap_pkg::tap_event_type      TAP_EVENT,
  output logic                        TAP_ACTIVE
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIRST,
    ST_REJECT,
    ST_LATENCY,
    ST_WINDOW,
    ST_SECOND
  } tap_fsm_type;

  typedef struct packed {
    logic [7:0]             z_thresh;
    logic [7:0]             width_limit;
    logic [7:0]             latency;
    logic [7:0]             window;
    tap_pkg::ctrl_type      ctrl;
    tap_pkg::tap_event_type seen;
    logic                   above;
    tap_fsm_type            state;
    logic [7:0]             rd_data;
    tap_pkg::tap_event_type event_out;
    logic                   active;
  } main_state_type;

  main_state_type s;
  main_state_type next_s;

  logic [tap_pkg::EXP_W-1:0]  width_exp;
  logic [tap_pkg::EXP_W-1:0]  gap_exp;
  logic [tap_pkg::STEP_W-1:0] width_step;
  logic [tap_pkg::STEP_W-1:0] gap_step;
  logic [13:0]                z_mag;
  logic                       sample_above;
  logic                       width_start;
  logic                       gap_start;
  logic                       width_expired;
  logic                       gap_expired;
  logic [7:0]                 gap_limit;

  // Step lengths follow rate, mode, filter path and hybrid doubling.
  always_comb
  begin
    width_exp  = tap_pkg::width_step_exp(s.ctrl.sample_rate, s.ctrl.mode, s.ctrl.hpf_en)
                 + {3'h0, s.ctrl.hybrid};
    gap_exp    = width_exp + 4'h1;
    width_step = tap_pkg::STEP_W'(BASE_STEP_CYCLES) << width_exp;
    gap_step   = tap_pkg::STEP_W'(BASE_STEP_CYCLES) << gap_exp;
  end

  // Compare the magnitude, cut to 1/16 g units, against the 8 g scale threshold.
  always_comb
  begin
    z_mag        = Z_ACCEL[13] ? (~Z_ACCEL + 14'h0001) : Z_ACCEL;
    sample_above = z_mag[13:tap_pkg::MAG_LSB] > s.z_thresh;
  end

  // The gap timer serves the latency and then the window; both share one step.
  assign gap_limit = (s.state == ST_WINDOW) ? s.window : s.latency;

  tap_step_timer #(
    .STEP_W      (tap_pkg::STEP_W)
  ) width_timer (
    .clk         (SYS_CLK),
    .arst_n      (ARST_N),
    .start       (width_start),
    .limit       (s.width_limit),
    .step_cycles (width_step),
    .expired     (width_expired)
  );

  tap_step_timer #(
    .STEP_W      (tap_pkg::STEP_W)
  ) gap_timer (
    .clk         (SYS_CLK),
    .arst_n      (ARST_N),
    .start       (gap_start),
    .limit       (gap_limit),
    .step_cycles (gap_step),
    .expired     (gap_expired)
  );

  always_comb
  begin
    next_s      = s;
    width_start = 1'b0;
    gap_start   = 1'b0;
    next_s.event_out = '0;

    if (Z_VALID)
    begin
      next_s.above = sample_above;
    end

    // Register writes.
    if (WR_EN)
    begin
      unique case (ADDR)
        tap_pkg::ADDR_Z_THRESH:    next_s.z_thresh    = WR_DATA & tap_pkg::THRESH_MASK;
        tap_pkg::ADDR_WIDTH_LIMIT: next_s.width_limit = WR_DATA;
        tap_pkg::ADDR_LATENCY:     next_s.latency     = WR_DATA;
        tap_pkg::ADDR_WINDOW:      next_s.window      = WR_DATA;
        tap_pkg::ADDR_CTRL:        next_s.ctrl        = tap_pkg::ctrl_type'(WR_DATA);
        default:                   next_s.ctrl        = s.ctrl;
      endcase
    end

    // Register reads; the status flags clear on read.
    next_s.rd_data = 8'h00;
    if (RD_EN)
    begin
      unique case (ADDR)
        tap_pkg::ADDR_Z_THRESH:    next_s.rd_data = s.z_thresh;
        tap_pkg::ADDR_WIDTH_LIMIT: next_s.rd_data = s.width_limit;
        tap_pkg::ADDR_LATENCY:     next_s.rd_data = s.latency;
        tap_pkg::ADDR_WINDOW:      next_s.rd_data = s.window;
        tap_pkg::ADDR_CTRL:        next_s.rd_data = s.ctrl;
        tap_pkg::ADDR_STATUS:
        begin
          next_s.rd_data = {5'h00, s.active, s.seen};
          next_s.seen    = '0;
        end
        default:                   next_s.rd_data = 8'h00;
      endcase
    end

    // Tap sequence.
    unique case (s.state)
      ST_IDLE:
      begin
        if (s.above)
        begin
          width_start  = 1'b1;
          next_s.state = ST_FIRST;
        end
      end
      ST_FIRST:
      begin
        if (width_expired)
        begin
          next_s.state = ST_REJECT;
        end
        else if (!s.above)
        begin
          next_s.event_out.single_tap = 1'b1;
          gap_start    = 1'b1;
          next_s.state = ST_LATENCY;
        end
      end
      ST_REJECT:
      begin
        if (!s.above)
        begin
          next_s.state = ST_IDLE;
        end
      end
      ST_LATENCY:
      begin
        if (gap_expired)
        begin
          gap_start    = s.ctrl.double_en;
          next_s.state = s.ctrl.double_en ? ST_WINDOW : ST_IDLE;
        end
      end
      ST_WINDOW:
      begin
        if (s.above)
        begin
          width_start  = 1'b1;
          next_s.state = ST_SECOND;
        end
        else if (gap_expired)
        begin
          next_s.state = ST_IDLE;
        end
      end
      ST_SECOND:
      begin
        if (width_expired)
        begin
          next_s.state = ST_REJECT;
        end
        else if (!s.above)
        begin
          next_s.event_out.double_tap = 1'b1;
          next_s.state = ST_IDLE;
        end
      end
      default:
      begin
        next_s.state = ST_IDLE;
      end
    endcase

    // An event in the same cycle as a status read stays flagged.
    next_s.seen   = next_s.seen | next_s.event_out;
    next_s.active = (next_s.state != ST_IDLE);
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign RD_DATA    = s.rd_data;
  assign TAP_EVENT  = s.event_out;
  assign TAP_ACTIVE = s.active;

  AST_THRESH_WRITE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (WR_EN && ADDR == tap_pkg::ADDR_Z_THRESH) |=> (s.z_thresh == ($past(WR_DATA) & 8'h7f)))
    else $error("Threshold write not stored as seven bits.");

  AST_WIDTH_READBACK: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (WR_EN && ADDR == tap_pkg::ADDR_WIDTH_LIMIT) ##1 (RD_EN && ADDR == tap_pkg::ADDR_WIDTH_LIMIT && !WR_EN)
      |=> (RD_DATA == $past(WR_DATA, 2)))
    else $error("Width limit did not read back.");

  AST_LATENCY_WRITE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (WR_EN && ADDR == tap_pkg::ADDR_LATENCY) |=> (s.latency == $past(WR_DATA)))
    else $error("Latency write not stored.");

  AST_PULSE_TOO_LONG: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_FIRST && width_expired) |=> (s.state == ST_REJECT && !TAP_EVENT.single_tap))
    else $error("Over-long pulse was not rejected.");

  AST_SINGLE_CAUSE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    TAP_EVENT.single_tap |-> (s.state == ST_LATENCY && $past(s.state) == ST_FIRST))
    else $error("Single tap without a valid first pulse.");

  AST_LATENCY_IGNORES: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_LATENCY && !gap_expired) |=> (s.state == ST_LATENCY))
    else $error("Latency interval left early.");

  AST_WINDOW_OPENS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_LATENCY && gap_expired && s.ctrl.double_en) |=> (s.state == ST_WINDOW))
    else $error("Window did not open after latency.");

  AST_DOUBLE_CAUSE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    TAP_EVENT.double_tap |-> ($past(s.state) == ST_SECOND && TAP_ACTIVE == 1'b0))
    else $error("Double tap without a second pulse.");

  AST_LATENCY_STEP: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    gap_step == (width_step << 1))
    else $error("Latency step is not twice the width step.");

  AST_HYBRID_DOUBLES: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    s.ctrl.hybrid |-> (width_step == (tap_pkg::STEP_W'(BASE_STEP_CYCLES)
      << tap_pkg::width_step_exp(s.ctrl.sample_rate, s.ctrl.mode, s.ctrl.hpf_en)) << 1))
    else $error("Hybrid operation did not double the step.");

  AST_THRESH_TOP_ZERO: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (RD_EN && ADDR == tap_pkg::ADDR_Z_THRESH) |=> !RD_DATA[7])
    else $error("Threshold top bit did not read zero.");

  AST_RD_IDLE_ZERO: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !RD_EN |=> (RD_DATA == 8'h00))
    else $error("Read data not zero outside a read.");

  AST_STATUS_CLEARS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (RD_EN && ADDR == tap_pkg::ADDR_STATUS && next_s.event_out == 2'b00) |=> (s.seen == 2'b00))
    else $error("Status flags did not clear on read.");

  AST_EVENT_FLAGGED: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.seen | TAP_EVENT) == s.seen)
    else $error("Tap event not kept in the status flags.");

  AST_EVENT_ONE_CYCLE: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    TAP_EVENT.single_tap |=> !TAP_EVENT.single_tap)
    else $error("Single tap pulse lasted more than one cycle.");

  AST_LATENCY_NO_START: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_LATENCY && s.above) |=> (s.state != ST_FIRST && s.state != ST_SECOND))
    else $error("Pulse start accepted during latency.");

  AST_REJECT_HOLDS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_REJECT && s.above) |=> (s.state == ST_REJECT))
    else $error("Rejected pulse left before falling below threshold.");

  AST_SECOND_TOO_LONG: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_SECOND && width_expired) |=> (s.state == ST_REJECT && !TAP_EVENT.double_tap))
    else $error("Over-long second pulse was not rejected.");

  AST_WINDOW_CLOSES: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_WINDOW && gap_expired && !s.above) |=> (s.state == ST_IDLE))
    else $error("Window did not close when it expired.");

  AST_SECOND_START: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_WINDOW && s.above) |=> (s.state == ST_SECOND))
    else $error("Second pulse start inside the window was missed.");

  AST_HIGH_RES_CAP: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.ctrl.mode == tap_pkg::MODE_HIGH_RES && !s.ctrl.hybrid) |-> (width_exp <= 4'h2))
    else $error("High resolution width step out of range.");

  AST_FIRST_START: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_IDLE && s.above) |=> (s.state == ST_FIRST))
    else $error("Pulse start did not open the width interval.");

  AST_FIRST_ENDS: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    (s.state == ST_FIRST && !width_expired && !s.above) |=> (s.state == ST_LATENCY && TAP_EVENT.single_tap))
    else $error("Valid first pulse did not give a single tap.");

endmodule

// File: verif/tb_tap_pulse_timing_config.sv
// Purpose: Self-checking bench for the tap threshold, width limit and latency timing.
// Assumes: Base step shortened to 4 cycles; Z samples arrive on every clock.
// Notes:   Expected step lengths are given in units of the 0.625 ms base step.
`timescale 1ns/100ps
module tb_tap_pulse_timing_config;
  localparam int BASE = 4;
  logic                   SYS_CLK = 1'b0;
  logic                   ARST_N  = 1'b0;
  logic [7:0]             ADDR    = 8'h00;
  logic [7:0]             WR_DATA = 8'h00;
  logic                   WR_EN   = 1'b0;
  logic                   RD_EN   = 1'b0;
  logic [7:0]             RD_DATA;
  logic [13:0]            Z_ACCEL = 14'h0000;
  logic                   Z_VALID = 1'b0;
  tap_pkg::tap_event_type TAP_EVENT;
  logic                   TAP_ACTIVE;
  int                     err_count = 0;
  int                     tests_run = 0;
  int                     cycles    = 0;
  int                     n_single  = 0;
  int                     n_double  = 0;

  tap_pulse_timing_config #(.BASE_STEP_CYCLES(BASE)) tap_pulse_timing_config_inst (
    .SYS_CLK    (SYS_CLK),
    .ARST_N     (ARST_N),
    .ADDR       (ADDR),
    .WR_DATA    (WR_DATA),
    .WR_EN      (WR_EN),
    .RD_EN      (RD_EN),
    .RD_DATA    (RD_DATA),
    .Z_ACCEL    (Z_ACCEL),
    .Z_VALID    (Z_VALID),
    .TAP_EVENT  (TAP_EVENT),
    .TAP_ACTIVE (TAP_ACTIVE)
  );

  always #4 SYS_CLK = ~SYS_CLK;

  // Event counters and the run ceiling.
  always @(posedge SYS_CLK)
  begin
    cycles <= cycles + 1;
    if (TAP_EVENT.single_tap === 1'b1)
      n_single <= n_single + 1;
    if (TAP_EVENT.double_tap === 1'b1)
      n_double <= n_double + 1;
    if (cycles == 60000)
    begin
      err_count = err_count + 1;
      $display("unexpected at %0t: run ceiling reached", $time);
      summarize();
    end
  end

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("unexpected at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR    <= a;
    WR_DATA <= d;
    WR_EN   <= 1'b1;
    @(posedge SYS_CLK);
    WR_EN   <= 1'b0;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge SYS_CLK);
    ADDR  <= a;
    RD_EN <= 1'b1;
    @(posedge SYS_CLK);
    RD_EN <= 1'b0;
    #1;
    check({24'h000000, RD_DATA}, {24'h000000, exp});
  endtask

  // Holds one Z value for n samples, then returns to rest.
  task automatic pulse(input logic [13:0] v, input int n);
    @(posedge SYS_CLK);
    Z_ACCEL <= v;
    repeat (n) @(posedge SYS_CLK);
    Z_ACCEL <= 14'h0000;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    repeat (6) @(posedge SYS_CLK);
    #1;
    while (TAP_ACTIVE !== 1'b0 && k < 4000)
    begin
      @(posedge SYS_CLK);
      #1;
      k++;
    end
    check({31'h0, TAP_ACTIVE}, 32'h0);
  endtask

  task automatic reg_test;
    rd_check(tap_pkg::ADDR_Z_THRESH, 8'h00);
    rd_check(tap_pkg::ADDR_WIDTH_LIMIT, 8'h00);
    rd_check(tap_pkg::ADDR_LATENCY, 8'h00);
    wr(tap_pkg::ADDR_Z_THRESH, 8'hff);
    rd_check(tap_pkg::ADDR_Z_THRESH, 8'h7f);
    wr(tap_pkg::ADDR_WIDTH_LIMIT, 8'ha5);
    rd_check(tap_pkg::ADDR_WIDTH_LIMIT, 8'ha5);
    wr(tap_pkg::ADDR_LATENCY, 8'h5a);
    rd_check(tap_pkg::ADDR_LATENCY, 8'h5a);
    wr(tap_pkg::ADDR_WINDOW, 8'h33);
    rd_check(tap_pkg::ADDR_WINDOW, 8'h33);
    // Write and read back to back, with no idle cycle between the strobes.
    @(posedge SYS_CLK);
    ADDR    <= tap_pkg::ADDR_WIDTH_LIMIT;
    WR_DATA <= 8'h3c;
    WR_EN   <= 1'b1;
    @(posedge SYS_CLK);
    WR_EN   <= 1'b0;
    RD_EN   <= 1'b1;
    @(posedge SYS_CLK);
    RD_EN   <= 1'b0;
    #1;
    check({24'h000000, RD_DATA}, 32'h0000003c);
    wr(8'h40, 8'hff);
    rd_check(8'h40, 8'h00);
    $display("test registers done");
  endtask

  // Threshold 16 counts: a magnitude of 1088 lies above it, 1087 does not.
  task automatic thresh_test;
    int s0;
    wr(tap_pkg::ADDR_Z_THRESH, 8'h10);
    wr(tap_pkg::ADDR_CTRL, 8'h00);
    wr(tap_pkg::ADDR_WIDTH_LIMIT, 8'h03);
    wr(tap_pkg::ADDR_LATENCY, 8'h00);
    s0 = n_single;
    pulse(14'd1087, 2);
    wait_idle();
    check(32'(n_single), 32'(s0));
    pulse(14'h3bc0, 2);
    wait_idle();
    check(32'(n_single), 32'(s0 + 1));
    rd_check(tap_pkg::ADDR_STATUS, 8'h01);
    rd_check(tap_pkg::ADDR_STATUS, 8'h00);
    wr(tap_pkg::ADDR_WIDTH_LIMIT, 8'h00);
    pulse(14'h07d0, 2);
    wait_idle();
    check(32'(n_single), 32'(s0 + 1));
    $display("test threshold done");
  endtask

  // Width limit 3: a pulse just under 3 steps passes, just over it is dropped.
  task automatic width_case(input logic [2:0] rate, input tap_pkg::power_mode_type mode,
                            input logic hpf, input logic hyb, input int units);
    int span;
    int s0;
    span = 3 * units * BASE;
    wr(tap_pkg::ADDR_CTRL, {1'b0, hyb, hpf, mode, rate});
    wr(tap_pkg::ADDR_WIDTH_LIMIT, 8'h03);
    wr(tap_pkg::ADDR_LATENCY, 8'h00);
    s0 = n_single;
    pulse(14'h07d0, span - 2);
    wait_idle();
    check(32'(n_single), 32'(s0 + 1));
    pulse(14'h3830, span + 2);
    wait_idle();
    check(32'(n_single), 32'(s0 + 1));
    $display("test width rate %0d mode %0d hpf %0d hybrid %0d done", rate, mode, hpf, hyb);
  endtask

  // Latency 3 and window 10 steps; second pulse starts delay cycles after the first event.
  task automatic dbl_case(input logic hpf, input int delay, input int exp);
    int s0;
    int d0;
    int k;
    wr(tap_pkg::ADDR_CTRL, {1'b1, 1'b0, hpf, tap_pkg::MODE_NORMAL, 3'h0});
    wr(tap_pkg::ADDR_WIDTH_LIMIT, 8'h03);
    wr(tap_pkg::ADDR_LATENCY, 8'h03);
    wr(tap_pkg::ADDR_WINDOW, 8'h0a);
    s0 = n_single;
    d0 = n_double;
    k = 0;
    pulse(14'h07d0, 4);
    while (n_single == s0 && k < 50)
    begin
      @(posedge SYS_CLK);
      #1;
      k++;
    end
    check(32'(n_single), 32'(s0 + 1));
    repeat (delay) @(posedge SYS_CLK);
    pulse(14'h07d0, 4);
    repeat (400) @(posedge SYS_CLK);
    #1;
    check(32'(n_double), 32'(d0 + exp));
    check({31'h0, TAP_ACTIVE}, 32'h0);
    $display("test double hpf %0d delay %0d done", hpf, delay);
  endtask

  initial
  begin
    repeat (6) @(posedge SYS_CLK);
    ARST_N  <= 1'b1;
    Z_VALID <= 1'b1;
    #1;
    check({29'h0, TAP_EVENT, TAP_ACTIVE}, 32'h0);
    reg_test();
    thresh_test();
    width_case(3'h0, tap_pkg::MODE_NORMAL, 1'b1, 1'b0, 2);
    width_case(3'h3, tap_pkg::MODE_HIGH_RES, 1'b1, 1'b0, 4);
    width_case(3'h7, tap_pkg::MODE_NORMAL, 1'b1, 1'b0, 32);
    width_case(3'h5, tap_pkg::MODE_LOW_NOISE, 1'b1, 1'b0, 128);
    width_case(3'h6, tap_pkg::MODE_LOW_POWER, 1'b1, 1'b0, 256);
    width_case(3'h0, tap_pkg::MODE_LOW_POWER, 1'b0, 1'b0, 1);
    width_case(3'h5, tap_pkg::MODE_HIGH_RES, 1'b0, 1'b0, 1);
    width_case(3'h4, tap_pkg::MODE_NORMAL, 1'b0, 1'b0, 8);
    width_case(3'h7, tap_pkg::MODE_LOW_NOISE, 1'b0, 1'b0, 32);
    width_case(3'h7, tap_pkg::MODE_LOW_POWER, 1'b0, 1'b0, 64);
    width_case(3'h0, tap_pkg::MODE_NORMAL, 1'b0, 1'b1, 2);
    dbl_case(1'b0, 10, 0);
    dbl_case(1'b0, 40, 1);
    dbl_case(1'b0, 124, 0);
    dbl_case(1'b1, 30, 0);
    dbl_case(1'b1, 70, 1);
    summarize();
  end
endmodule
